// ===== hdl/ifd_consts.vh
// Constants for the instruction operand field decoder
`ifndef IFD_CONSTS_VH
`define IFD_CONSTS_VH

// Field positions within the 16-bit instruction word
`define IFD_OP_HI        15
`define IFD_OP_LO        12
`define IFD_NF_HI        11
`define IFD_NF_LO        8
`define IFD_MF_HI        7
`define IFD_MF_LO        4
`define IFD_LO_HI        3
`define IFD_LO_LO        0

// Format codes
`define IFD_FMT_ZERO     4'h0
`define IFD_FMT_N        4'h1
`define IFD_FMT_M        4'h2
`define IFD_FMT_NM       4'h3
`define IFD_FMT_MD       4'h4
`define IFD_FMT_ND4      4'h5
`define IFD_FMT_NMD      4'h6
`define IFD_FMT_D        4'h7
`define IFD_FMT_D12      4'h8
`define IFD_FMT_ND8      4'h9
`define IFD_FMT_I        4'ha
`define IFD_FMT_NI       4'hb
`define IFD_FMT_BAD      4'hf

// Operand usage codes
`define IFD_MODE_NONE    4'h0
`define IFD_MODE_DIRECT  4'h1
`define IFD_MODE_IND     4'h2
`define IFD_MODE_POSTINC 4'h3
`define IFD_MODE_PREDEC  4'h4
`define IFD_MODE_DISP4   4'h5
`define IFD_MODE_ZIDX    4'h6
`define IFD_MODE_GBP_DSP 4'h7
`define IFD_MODE_GBP_IDX 4'h8
`define IFD_MODE_PC_DISP 4'h9
`define IFD_MODE_PC_REL  4'ha
`define IFD_MODE_CTRL    4'hb
`define IFD_MODE_ACCUM   4'hc
`define IFD_MODE_IMM     4'hd
`define IFD_MODE_ZREG    4'he

// Implicit index register zero
`define IFD_REG_ZERO     4'h0

`endif

// ===== hdl/ifd_field_decoder.v
// Operand field decoder for 16-bit instruction words
`timescale 1ns/100ps
`include "ifd_consts.vh"

module ifd_field_decoder (
    input  wire        REF_CLK_I,
    input  wire        SYS_RST_I,
    input  wire        CLK_EN_I,
    input  wire        INSN_VALID_I,
    input  wire [15:0] INSN_WORD_I,
    output wire        DEC_VALID_O,
    output wire [3:0]  FMT_O,
    output wire [3:0]  DEST_REG_O,
    output wire [3:0]  DEST_MODE_O,
    output wire [3:0]  SRC_REG_O,
    output wire [3:0]  SRC_MODE_O,
    output wire [3:0]  SRC2_REG_O,
    output wire [3:0]  SRC2_MODE_O,
    output wire [11:0] DISP_O,
    output wire [31:0] IMM_O,
    output wire        ILLEGAL_O
);

    wire [3:0] op = INSN_WORD_I[`IFD_OP_HI:`IFD_OP_LO];
    wire [3:0] nf = INSN_WORD_I[`IFD_NF_HI:`IFD_NF_LO];
    wire [3:0] mf = INSN_WORD_I[`IFD_MF_HI:`IFD_MF_LO];
    wire [3:0] lo = INSN_WORD_I[`IFD_LO_HI:`IFD_LO_LO];
    wire [7:0] lb = INSN_WORD_I[7:0];

    reg        valid_r;
    reg        illegal_r;
    reg [71:0] dec_r;

    reg [3:0]  fmt_nxt;
    reg [3:0]  dst_nxt;
    reg [3:0]  dmode_nxt;
    reg [3:0]  src_nxt;
    reg [3:0]  smode_nxt;
    reg [3:0]  src2_nxt;
    reg [3:0]  s2mode_nxt;
    reg [11:0] disp_nxt;
    reg [31:0] imm_nxt;

    // Packed so that reset and load touch one register
    wire [71:0] dec_nxt = {fmt_nxt, dst_nxt, dmode_nxt, src_nxt, smode_nxt,
                           src2_nxt, s2mode_nxt, disp_nxt, imm_nxt};

    always @* begin
        fmt_nxt    = `IFD_FMT_BAD;
        dst_nxt    = `IFD_REG_ZERO;
        dmode_nxt  = `IFD_MODE_NONE;
        src_nxt    = `IFD_REG_ZERO;
        smode_nxt  = `IFD_MODE_NONE;
        src2_nxt   = `IFD_REG_ZERO;
        s2mode_nxt = `IFD_MODE_NONE;
        disp_nxt   = 12'h000;
        imm_nxt    = 32'h0000_0000;
        case (op)
            4'h0: begin
                if (lo == 4'h4 || lo == 4'h5 || lo == 4'h6) begin
                    fmt_nxt   = `IFD_FMT_NM;
                    dst_nxt   = nf;
                    dmode_nxt = `IFD_MODE_ZIDX;
                    src_nxt   = mf;
                    smode_nxt = `IFD_MODE_DIRECT;
                end else if (lo == 4'hc || lo == 4'hd || lo == 4'he) begin
                    fmt_nxt   = `IFD_FMT_NM;
                    dst_nxt   = nf;
                    dmode_nxt = `IFD_MODE_DIRECT;
                    src_nxt   = mf;
                    smode_nxt = `IFD_MODE_ZIDX;
                end else if (lo == 4'h7) begin
                    fmt_nxt    = `IFD_FMT_NM;
                    dmode_nxt  = `IFD_MODE_ACCUM;
                    src_nxt    = mf;
                    smode_nxt  = `IFD_MODE_DIRECT;
                    src2_nxt   = nf;
                    s2mode_nxt = `IFD_MODE_DIRECT;
                end else if (lo == 4'hf) begin
                    fmt_nxt    = `IFD_FMT_NM;
                    dmode_nxt  = `IFD_MODE_ACCUM;
                    src_nxt    = mf;
                    smode_nxt  = `IFD_MODE_POSTINC;
                    src2_nxt   = nf;
                    s2mode_nxt = `IFD_MODE_POSTINC;
                end else if (lo == 4'h2 || lo == 4'ha ||
                             (lo == 4'h9 && mf == 4'h2)) begin
                    fmt_nxt   = `IFD_FMT_N;
                    dst_nxt   = nf;
                    dmode_nxt = `IFD_MODE_DIRECT;
                    smode_nxt = (lo == 4'h9) ? `IFD_MODE_NONE
                                             : `IFD_MODE_CTRL;
                end else if (lo == 4'h3) begin
                    fmt_nxt   = `IFD_FMT_M;
                    src_nxt   = nf;
                    smode_nxt = `IFD_MODE_PC_REL;
                end else if ((lo == 4'h8 || lo == 4'h9 || lo == 4'hb)
                             && nf == 4'h0) begin
                    fmt_nxt = `IFD_FMT_ZERO;
                end
            end
            4'h1, 4'h5: begin
                // Three fields; opcode bit 2 moves the displacement
                fmt_nxt   = `IFD_FMT_NMD;
                dst_nxt   = nf;
                src_nxt   = mf;
                dmode_nxt = op[2] ? `IFD_MODE_DIRECT : `IFD_MODE_DISP4;
                smode_nxt = op[2] ? `IFD_MODE_DISP4 : `IFD_MODE_DIRECT;
                disp_nxt  = {8'h00, lo};
            end
            4'h2, 4'h3, 4'h6: begin
                fmt_nxt   = `IFD_FMT_NM;
                dst_nxt   = nf;
                dmode_nxt = `IFD_MODE_DIRECT;
                src_nxt   = mf;
                smode_nxt = `IFD_MODE_DIRECT;
                if (op == 4'h2 && lo <= 4'h2)
                    dmode_nxt = `IFD_MODE_IND;
                else if (op == 4'h2 && lo >= 4'h4 && lo <= 4'h6)
                    dmode_nxt = `IFD_MODE_PREDEC;
                else if (op == 4'h6 && lo >= 4'h4 && lo <= 4'h6)
                    smode_nxt = `IFD_MODE_POSTINC;
            end
            4'h4: begin
                if (lo == 4'hf) begin
                    fmt_nxt    = `IFD_FMT_NM;
                    dmode_nxt  = `IFD_MODE_ACCUM;
                    src_nxt    = mf;
                    smode_nxt  = `IFD_MODE_POSTINC;
                    src2_nxt   = nf;
                    s2mode_nxt = `IFD_MODE_POSTINC;
                end else if (lo == 4'h2 || lo == 4'h3) begin
                    fmt_nxt   = `IFD_FMT_N;
                    dst_nxt   = nf;
                    dmode_nxt = `IFD_MODE_PREDEC;
                    smode_nxt = `IFD_MODE_CTRL;
                end else if (lo == 4'h6 || lo == 4'h7) begin
                    fmt_nxt   = `IFD_FMT_M;
                    src_nxt   = nf;
                    smode_nxt = `IFD_MODE_POSTINC;
                    dmode_nxt = `IFD_MODE_CTRL;
                end else if (lo == 4'ha || lo == 4'he) begin
                    fmt_nxt   = `IFD_FMT_M;
                    src_nxt   = nf;
                    smode_nxt = `IFD_MODE_DIRECT;
                    dmode_nxt = `IFD_MODE_CTRL;
                end else if (lo == 4'hb) begin
                    fmt_nxt   = `IFD_FMT_M;
                    src_nxt   = nf;
                    smode_nxt = `IFD_MODE_IND;
                end else begin
                    fmt_nxt   = `IFD_FMT_N;
                    dst_nxt   = nf;
                    dmode_nxt = `IFD_MODE_DIRECT;
                end
            end
            4'h7, 4'he: begin
                fmt_nxt   = `IFD_FMT_NI;
                dst_nxt   = nf;
                dmode_nxt = `IFD_MODE_DIRECT;
                smode_nxt = `IFD_MODE_IMM;
                imm_nxt   = {{24{lb[7]}}, lb};
            end
            4'h8: begin
                if (nf == 4'h0 || nf == 4'h1) begin
                    fmt_nxt   = `IFD_FMT_ND4;
                    dst_nxt   = mf;
                    dmode_nxt = `IFD_MODE_DISP4;
                    smode_nxt = `IFD_MODE_ZREG;
                    disp_nxt  = {8'h00, lo};
                end else if (nf == 4'h4 || nf == 4'h5) begin
                    fmt_nxt   = `IFD_FMT_MD;
                    src_nxt   = mf;
                    smode_nxt = `IFD_MODE_DISP4;
                    dmode_nxt = `IFD_MODE_ZREG;
                    disp_nxt  = {8'h00, lo};
                end else if (nf == 4'h8) begin
                    fmt_nxt   = `IFD_FMT_I;
                    smode_nxt = `IFD_MODE_IMM;
                    dmode_nxt = `IFD_MODE_ZREG;
                    imm_nxt   = {{24{lb[7]}}, lb};
                end else if (nf[0]) begin
                    fmt_nxt   = `IFD_FMT_D;
                    smode_nxt = `IFD_MODE_PC_REL;
                    disp_nxt  = {4'h0, lb};
                end
            end
            4'h9, 4'hd: begin
                fmt_nxt   = `IFD_FMT_ND8;
                dst_nxt   = nf;
                dmode_nxt = `IFD_MODE_DIRECT;
                smode_nxt = `IFD_MODE_PC_DISP;
                disp_nxt  = {4'h0, lb};
            end
            4'ha, 4'hb: begin
                fmt_nxt   = `IFD_FMT_D12;
                smode_nxt = `IFD_MODE_PC_REL;
                disp_nxt  = INSN_WORD_I[11:0];
            end
            4'hc: begin
                fmt_nxt  = `IFD_FMT_D;
                disp_nxt = {4'h0, lb};
                if (nf <= 4'h2) begin
                    smode_nxt = `IFD_MODE_ZREG;
                    dmode_nxt = `IFD_MODE_GBP_DSP;
                end else if (nf == 4'h3) begin
                    // Trap vector number is scaled by four
                    fmt_nxt   = `IFD_FMT_I;
                    disp_nxt  = 12'h000;
                    smode_nxt = `IFD_MODE_IMM;
                    imm_nxt   = {22'h000000, lb, 2'b00};
                end else if (nf <= 4'h6) begin
                    smode_nxt = `IFD_MODE_GBP_DSP;
                    dmode_nxt = `IFD_MODE_ZREG;
                end else if (nf == 4'h7) begin
                    smode_nxt = `IFD_MODE_PC_DISP;
                    dmode_nxt = `IFD_MODE_ZREG;
                end else begin
                    // Logic immediates are zero-extended
                    fmt_nxt   = `IFD_FMT_I;
                    disp_nxt  = 12'h000;
                    smode_nxt = `IFD_MODE_IMM;
                    imm_nxt   = {24'h000000, lb};
                    dmode_nxt = nf[2] ? `IFD_MODE_GBP_IDX : `IFD_MODE_ZREG;
                end
            end
            default: fmt_nxt = `IFD_FMT_BAD;
        endcase
    end

    // Outputs hold the last decode while no word is offered
    always @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            // Every reset code is zero, so one clear covers all fields
            valid_r   <= 1'b0;
            illegal_r <= 1'b0;
            dec_r     <= 72'h0;
        end else if (CLK_EN_I) begin
            valid_r <= INSN_VALID_I;
            if (INSN_VALID_I) begin
                dec_r     <= dec_nxt;
                // Own flop so the flag leaves no decode gate on the pin
                illegal_r <= (fmt_nxt == `IFD_FMT_BAD);
            end
        end
    end

    assign DEC_VALID_O = valid_r;
    assign FMT_O       = dec_r[71:68];
    assign DEST_REG_O  = dec_r[67:64];
    assign DEST_MODE_O = dec_r[63:60];
    assign SRC_REG_O   = dec_r[59:56];
    assign SRC_MODE_O  = dec_r[55:52];
    assign SRC2_REG_O  = dec_r[51:48];
    assign SRC2_MODE_O = dec_r[47:44];
    assign DISP_O      = dec_r[43:32];
    assign IMM_O       = dec_r[31:0];
    assign ILLEGAL_O   = illegal_r;

endmodule

// ===== sim/ifd_fetch_model.sv
// Behavioural fetch stage offering instruction words to the decoder
`timescale 1ns/100ps
module ifd_fetch_model (
    input  wire logic        clk_i,
    input  wire logic        offer_i,
    input  wire logic [15:0] word_i,
    output wire logic        valid_o,
    output wire logic [15:0] word_o
);
    logic [15:0] idle_r = 16'h0000;
    // Idle bus toggles between the complement of the last word and the stale word itself
    always @(posedge clk_i) begin
        idle_r <= offer_i ? ~word_i : ~idle_r;
    end
    assign valid_o = offer_i;
    assign word_o  = offer_i ? word_i : idle_r;
endmodule

// ===== sim/ifd_field_decoder_checker.sv
// Port-level assertions for the operand field decoder
`timescale 1ns/100ps
`include "ifd_consts.vh"
module ifd_field_decoder_checker (
    input wire logic        REF_CLK_I,
    input wire logic        SYS_RST_I,
    input wire logic        CLK_EN_I,
    input wire logic        INSN_VALID_I,
    input wire logic [15:0] INSN_WORD_I,
    input wire logic        DEC_VALID_O,
    input wire logic [3:0]  FMT_O,
    input wire logic [3:0]  DEST_REG_O,
    input wire logic [3:0]  SRC_REG_O,
    input wire logic [3:0]  SRC_MODE_O,
    input wire logic [11:0] DISP_O,
    input wire logic        ILLEGAL_O
);
    wire       take = CLK_EN_I && INSN_VALID_I;
    wire [3:0] op   = INSN_WORD_I[15:12];
    wire [3:0] nf   = INSN_WORD_I[11:8];
    wire [3:0] mf   = INSN_WORD_I[7:4];
    wire [3:0] lo   = INSN_WORD_I[3:0];
    wire [7:0] lb   = INSN_WORD_I[7:0];
    wire [11:0] lw  = INSN_WORD_I[11:0];
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (SYS_RST_I);

    property p_rst;
        disable iff (1'b0) SYS_RST_I |=> !DEC_VALID_O && FMT_O == 4'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("reset not cleared");
    property p_take; take |=> DEC_VALID_O; endproperty
    a_take: assert property (p_take) else $error("taken word no valid");
    property p_idle;
        CLK_EN_I && !INSN_VALID_I |=> !DEC_VALID_O && $stable(FMT_O)
            && $stable(DISP_O);
    endproperty
    a_idle: assert property (p_idle) else $error("idle cycle changed");
    property p_frz; !CLK_EN_I |=> $stable(DEC_VALID_O) && $stable(SRC_REG_O);
    endproperty
    a_frz: assert property (p_frz) else $error("state moved while frozen");
    property p_ill; ILLEGAL_O == (FMT_O == `IFD_FMT_BAD); endproperty
    a_ill: assert property (p_ill) else $error("illegal flag wrong");
    property p_nm;
        take && op == 4'h3 |=> FMT_O == `IFD_FMT_NM
            && DEST_REG_O == $past(nf) && SRC_REG_O == $past(mf);
    endproperty
    a_nm: assert property (p_nm) else $error("nm fields wrong");
    property p_nmd;
        take && op == 4'h1 |=> FMT_O == `IFD_FMT_NMD
            && DEST_REG_O == $past(nf) && DISP_O == {8'h00, $past(lo)};
    endproperty
    a_nmd: assert property (p_nmd) else $error("nmd fields wrong");
    property p_pinc;
        take && op == 4'h6 && lo inside {[4'h4:4'h6]} |=>
            SRC_MODE_O == `IFD_MODE_POSTINC && SRC_REG_O == $past(mf);
    endproperty
    a_pinc: assert property (p_pinc) else $error("postinc wrong");
    property p_nd8;
        take && op == 4'h9 |=> DEST_REG_O == $past(nf)
            && DISP_O == {4'h0, $past(lb)};
    endproperty
    a_nd8: assert property (p_nd8) else $error("nd8 fields wrong");
    property p_d12;
        take && op[3:1] == 3'h5 |=> FMT_O == `IFD_FMT_D12
            && DISP_O == $past(lw);
    endproperty
    a_d12: assert property (p_d12) else $error("d12 fields wrong");
endmodule

bind ifd_field_decoder ifd_field_decoder_checker ifd_field_decoder_checker_i (
    .REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I), .CLK_EN_I(CLK_EN_I),
    .INSN_VALID_I(INSN_VALID_I), .INSN_WORD_I(INSN_WORD_I),
    .DEC_VALID_O(DEC_VALID_O), .FMT_O(FMT_O), .DEST_REG_O(DEST_REG_O),
    .SRC_REG_O(SRC_REG_O), .SRC_MODE_O(SRC_MODE_O), .DISP_O(DISP_O),
    .ILLEGAL_O(ILLEGAL_O));

// ===== sim/ifd_field_decoder_tb_top.sv
// Self-checking bench for the operand field decoder
`timescale 1ns/100ps
module ifd_field_decoder_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        en = 1'b1;
    logic        offer = 1'b0;
    logic [15:0] word = 16'h0000;
    wire         vld, ivld, ill;
    wire  [15:0] iword;
    wire  [3:0]  fmt, dreg, dmode, sreg, smode, s2reg, s2mode;
    wire  [11:0] disp;
    wire  [31:0] imm;
    int          fail_count = 0;
    int          check_count = 0;

    ifd_fetch_model ifd_fetch_model_i (.clk_i(clk), .offer_i(offer),
        .word_i(word), .valid_o(ivld), .word_o(iword));
    ifd_field_decoder ifd_field_decoder_i (.REF_CLK_I(clk), .SYS_RST_I(rst),
        .CLK_EN_I(en), .INSN_VALID_I(ivld), .INSN_WORD_I(iword),
        .DEC_VALID_O(vld), .FMT_O(fmt), .DEST_REG_O(dreg),
        .DEST_MODE_O(dmode), .SRC_REG_O(sreg), .SRC_MODE_O(smode),
        .SRC2_REG_O(s2reg), .SRC2_MODE_O(s2mode), .DISP_O(disp),
        .IMM_O(imm), .ILLEGAL_O(ill));

    initial begin
        forever #25 clk = ~clk;
    end

    task print_verdict;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t word %h got %h exp %h", $time, word,
                     got, exp);
        end
    endtask

    task dec(input logic [15:0] w);
        @(posedge clk);
        #1 offer = 1'b1;
        word = w;
        @(posedge clk);
        #1 offer = 1'b0;
    endtask

    task chk_ops(input logic [15:0] w, input logic [3:0] f, xd, xdm, xs, xsm,
                 input logic [1:0] msk);
        dec(w);
        cmp(vld, 1'b1);
        cmp(fmt, f);
        cmp(dmode, xdm);
        cmp(smode, xsm);
        if (msk[1]) cmp(dreg, xd);
        if (msk[0]) cmp(sreg, xs);
    endtask

    task chk_disp(input logic [15:0] w, input logic [3:0] f,
                  input logic [11:0] d);
        dec(w);
        cmp(fmt, f);
        cmp(disp, d);
    endtask

    task chk_imm(input logic [15:0] w, input logic [3:0] f,
                 input logic [31:0] i);
        dec(w);
        cmp(fmt, f);
        cmp(imm, i);
    endtask

    task t_two;
        chk_ops(16'h6346, 4'h3, 4'h3, 4'h1, 4'h4, 4'h3, 2'h3);
        chk_ops(16'h3c5c, 4'h3, 4'hc, 4'h1, 4'h5, 4'h1, 2'h3);
        chk_ops(16'h0a54, 4'h3, 4'ha, 4'h6, 4'h5, 4'h1, 2'h3);
        chk_ops(16'h2126, 4'h3, 4'h1, 4'h4, 4'h2, 4'h1, 2'h3);
    endtask

    task t_disp;
        chk_ops(16'h84a7, 4'h4, 4'h0, 4'he, 4'ha, 4'h5, 2'h3);
        chk_disp(16'h84a7, 4'h4, 12'h007);
        chk_ops(16'h81b3, 4'h5, 4'hb, 4'h5, 4'h0, 4'he, 2'h3);
        chk_disp(16'h81b3, 4'h5, 12'h003);
        chk_ops(16'h1ab9, 4'h6, 4'ha, 4'h5, 4'hb, 4'h1, 2'h3);
        chk_ops(16'h5cd2, 4'h6, 4'hc, 4'h1, 4'hd, 4'h5, 2'h3);
        chk_disp(16'h5cd2, 4'h6, 12'h002);
    endtask

    task t_single;
        chk_ops(16'h4703, 4'h1, 4'h7, 4'h4, 4'h0, 4'hb, 2'h2);
        chk_ops(16'h0502, 4'h1, 4'h5, 4'h1, 4'h0, 4'hb, 2'h2);
        chk_ops(16'h4e0e, 4'h2, 4'h0, 4'hb, 4'he, 4'h1, 2'h1);
        chk_ops(16'h432b, 4'h2, 4'h0, 4'h0, 4'h3, 4'h2, 2'h1);
        chk_ops(16'h0623, 4'h2, 4'h0, 4'h0, 4'h6, 4'ha, 2'h1);
        chk_ops(16'h4907, 4'h2, 4'h0, 4'hb, 4'h9, 4'h3, 2'h1);
    endtask

    task t_mac;
        chk_ops(16'h0a5f, 4'h3, 4'h0, 4'hc, 4'h5, 4'h3, 2'h1);
        cmp(s2reg, 4'ha);
        cmp(s2mode, 4'h3);
        chk_ops(16'h4c7f, 4'h3, 4'h0, 4'hc, 4'h7, 4'h3, 2'h1);
        cmp(s2reg, 4'hc);
    endtask

    task t_eight;
        chk_ops(16'h9c80, 4'h9, 4'hc, 4'h1, 4'h0, 4'h9, 2'h2);
        chk_disp(16'h9c80, 4'h9, 12'h080);
        chk_imm(16'he5f0, 4'hb, 32'hfffffff0);
        chk_imm(16'hc9f0, 4'ha, 32'h000000f0);
        chk_imm(16'hc321, 4'ha, 32'h00000084);
        chk_disp(16'hc7ff, 4'h7, 12'h0ff);
        chk_disp(16'h89fe, 4'h7, 12'h0fe);
    endtask

    task t_long;
        chk_disp(16'ha8f3, 4'h8, 12'h8f3);
        chk_disp(16'hbfff, 4'h8, 12'hfff);
        chk_disp(16'hb000, 4'h8, 12'h000);
    endtask

    task t_illegal;
        chk_ops(16'hffff, 4'hf, 4'h0, 4'h0, 4'h0, 4'h0, 2'h3);
        cmp(ill, 1'b1);
        chk_ops(16'h0121, 4'hf, 4'h0, 4'h0, 4'h0, 4'h0, 2'h3);
    endtask

    // Forms the other scenarios leave untouched
    task t_more;
        chk_ops(16'h0b8c, 4'h3, 4'hb, 4'h1, 4'h8, 4'h6, 2'h3);
        cmp(ill, 1'b0);
        chk_ops(16'h0237, 4'h3, 4'h0, 4'hc, 4'h3, 4'h1, 2'h1);
        cmp(s2reg, 4'h2);
        cmp(s2mode, 4'h1);
        chk_ops(16'h0009, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 2'h3);
        chk_ops(16'h0729, 4'h1, 4'h7, 4'h1, 4'h0, 4'h0, 2'h2);
        chk_ops(16'h2a31, 4'h3, 4'ha, 4'h2, 4'h3, 4'h1, 2'h3);
        chk_ops(16'h4d15, 4'h1, 4'hd, 4'h1, 4'h0, 4'h0, 2'h2);
        chk_ops(16'h88f9, 4'ha, 4'h0, 4'he, 4'h0, 4'hd, 2'h3);
        cmp(imm, 32'hfffffff9);
        chk_ops(16'hc13c, 4'h7, 4'h0, 4'h7, 4'h0, 4'he, 2'h3);
        cmp(disp, 12'h03c);
        chk_ops(16'hc57f, 4'h7, 4'h0, 4'he, 4'h0, 4'h7, 2'h3);
        chk_ops(16'hcd0f, 4'ha, 4'h0, 4'h8, 4'h0, 4'hd, 2'h3);
        cmp(imm, 32'h0000000f);
    endtask

    // Back-to-back words, a frozen stretch, then reset in mid-run
    task t_flow;
        @(posedge clk);
        #1 offer = 1'b1;
        word = 16'h6346;
        @(posedge clk);
        #1 word = 16'h3c5c;
        @(posedge clk);
        #1 en = 1'b0;
        word = 16'hffff;
        cmp(vld, 1'b1);
        cmp(dreg, 4'hc);
        repeat (2) @(posedge clk);
        #1 cmp(fmt, 4'h3);
        cmp(vld, 1'b1);
        en = 1'b1;
        offer = 1'b0;
        @(posedge clk);
        #1 cmp(vld, 1'b0);
        cmp(sreg, 4'h5);
        rst = 1'b1;
        @(posedge clk);
        #1 rst = 1'b0;
        cmp(fmt, 4'h0);
        cmp(dreg, 4'h0);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        cmp(vld, 1'b0);
        cmp(imm, 32'h00000000);
        t_two;
        t_disp;
        t_single;
        t_mac;
        t_eight;
        t_long;
        t_illegal;
        t_more;
        t_flow;
        print_verdict;
    end

    initial begin
        #(50 * 2000);
        fail_count++;
        print_verdict;
    end
endmodule
